/* hw/cmfs_consts.vh */
`ifndef CMFS_CONSTS_VH
`define CMFS_CONSTS_VH
`define CMFS_ADDR_W       15
`define CMFS_MADDR_W      13
`define CMFS_WORD_W       16
`define CMFS_CELL_W       17
`define CMFS_MOD_WORDS    8192
`define CMFS_MOD_MAX      4
`define CMFS_NUM_MODULES  4
`define CMFS_CYCLE_NS     750
`define CMFS_CLK_PS       8000
`define CMFS_CYCLE_CLKS   ((`CMFS_CYCLE_NS * 1000 + `CMFS_CLK_PS - 1) / `CMFS_CLK_PS)
`define CMFS_EX_NEXT      2'h0
`define CMFS_EX_HALT      2'h1
`define CMFS_EX_BRANCH    2'h2
`define CMFS_EX_SKIP      2'h3
`define CMFS_DEST_CTL     1'h0
`define CMFS_DEST_ARITH   1'h1
`define CMFS_EMPTY_CELL   17'h10000
`endif

/* hw/cmfs_mem_module.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmfs_consts.vh"
module cmfs_mem_module (
  input  wire        core_clk_in, // system clock
  input  wire        srst_in,     // synchronous reset, active high
  input  wire        start_in,    // command pulse, loads address register, and data register on a write
  input  wire        write_in,    // 1 write, 0 read
  input  wire [12:0] addr_in,     // location within the module
  input  wire [16:0] wdata_in,    // word plus parity for a write
  output reg         done_out,    // one-cycle pulse at end of cycle
  output reg  [16:0] data_out     // data register
);
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_ACT   = 2'h2;
  localparam [31:0] CYC_CLKS = `CMFS_CYCLE_CLKS;
  localparam [6:0]  CYC_LAST = CYC_CLKS[6:0] - 7'h01;

  reg [16:0] cells [0:`CMFS_MOD_WORDS-1];
  reg [12:0] addr_reg;
  reg        write_op;
  reg [1:0]  state;
  reg [6:0]  cnt;

  wire sense   = (state == ST_ACT) && (cnt == 7'h00) && !write_op;
  wire restore = (state == ST_ACT) && (cnt == CYC_LAST);

  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state    <= ST_IDLE;
      cnt      <= 7'h00;
      addr_reg <= 13'h0000;
      write_op <= 1'b0;
      data_out <= 17'h00000;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start_in)
          begin
            addr_reg <= addr_in;
            write_op <= write_in;
            if (write_in)
              data_out <= wdata_in;
            cnt   <= 7'h00;
            state <= ST_ACT;
          end
        end
        ST_ACT:
        begin
          if (sense)
            data_out <= cells[addr_reg];
          if (restore)
          begin
            done_out <= 1'b1;
            state    <= ST_IDLE;
          end
          else
            cnt <= cnt + 7'h01;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // sensing clears the cell; the end of the cycle writes the data register back
  always @(posedge core_clk_in)
  begin
    if (sense)
      cells[addr_reg] <= 17'h00000;
    else if (restore)
      cells[addr_reg] <= data_out;
  end
endmodule
`default_nettype wire

/* hw/cmfs_core.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmfs_consts.vh"
module cmfs_core (
  input  wire        core_clk_in,    // system clock
  input  wire        srst_in,        // synchronous reset, active high
  input  wire        start_in,       // start execution pulse, taken while halted
  input  wire [14:0] start_addr_in,  // address of first instruction
  input  wire        req_valid_in,   // memory request from mainframe
  input  wire        req_write_in,   // 1 write, 0 read
  input  wire        req_dest_in,    // read destination: 0 control, 1 arithmetic
  input  wire [14:0] req_addr_in,    // request address
  input  wire [15:0] req_wdata_in,   // word to write
  input  wire        exec_done_in,   // current instruction finished
  input  wire [1:0]  exec_kind_in,   // next, halt, branch, skip
  input  wire [14:0] exec_target_in, // branch operand address
  input  wire        skip_cond_in,   // skip condition holds
  input  wire        par_err_clr_in, // clear parity error flag
  output reg         req_busy_out,   // request in flight
  output reg         wr_done_out,    // write finished pulse
  output reg         instr_valid_out,// word to control pulse
  output reg  [15:0] instr_word_out, // word to control
  output reg  [14:0] instr_addr_out, // address of word to control
  output reg         oper_valid_out, // operand to arithmetic pulse
  output reg  [15:0] oper_word_out,  // operand to arithmetic
  output reg         par_err_out,    // sticky parity error
  output reg  [14:0] pc_out,         // program counter
  output reg         running_out,    // executing
  output reg         halted_out      // halt taken pulse
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ADV   = 5'h02;
  localparam [4:0] ST_FETCH = 5'h04;
  localparam [4:0] ST_FWAIT = 5'h08;
  localparam [4:0] ST_EXEC  = 5'h10;

  function [1:0] mod_of;
    input [14:0] addr;
    begin
      mod_of = addr[14:13];
    end
  endfunction

  function odd_par;
    input [15:0] word;
    begin
      odd_par = ~^word;
    end
  endfunction

  reg  [4:0]  state;
  reg  [1:0]  cur_mod;
  reg         host_wr;
  reg         host_dest;

  wire [1:0]  fetch_mod = mod_of(pc_out);
  wire [1:0]  host_mod  = mod_of(req_addr_in);
  wire        host_acc  = req_valid_in && !req_busy_out &&
                          (state != ST_FETCH) && (state != ST_FWAIT);
  wire        fetch_go  = (state == ST_FETCH) && !req_busy_out;
  wire        mem_go    = host_acc || fetch_go;
  wire [1:0]  mem_mod   = fetch_go ? fetch_mod : host_mod;
  wire        mem_write = fetch_go ? 1'b0 : req_write_in;
  wire [12:0] mem_addr  = fetch_go ? pc_out[12:0] : req_addr_in[12:0];
  wire [16:0] mem_wdata = {odd_par(req_wdata_in), req_wdata_in};

  wire [`CMFS_MOD_MAX-1:0]             done_vec;
  wire [`CMFS_MOD_MAX*`CMFS_CELL_W-1:0] rdata_flat;

  genvar m;
  generate
    for (m = 0; m < `CMFS_MOD_MAX; m = m + 1)
    begin : g_mod
      if (m < `CMFS_NUM_MODULES)
      begin : g_fit
        cmfs_mem_module u_mod (
          .core_clk_in (core_clk_in),
          .srst_in     (srst_in),
          .start_in    (mem_go && (mem_mod == m)),
          .write_in    (mem_write),
          .addr_in     (mem_addr),
          .wdata_in    (mem_wdata),
          .done_out    (done_vec[m]),
          .data_out    (rdata_flat[m*`CMFS_CELL_W +: `CMFS_CELL_W])
        );
      end
      else
      begin : g_empty
        // absent module answers at once with a zero word of good parity
        assign done_vec[m] = 1'b1;
        assign rdata_flat[m*`CMFS_CELL_W +: `CMFS_CELL_W] = `CMFS_EMPTY_CELL;
      end
    end
  endgenerate

  wire [16:0] rd_cell  = rdata_flat[cur_mod*`CMFS_CELL_W +: `CMFS_CELL_W];
  wire        rd_done  = done_vec[cur_mod];
  wire        host_rd  = req_busy_out && rd_done && !host_wr;
  wire        fetch_rd = (state == ST_FWAIT) && rd_done;
  wire        rd_bad   = (host_rd || fetch_rd) && !(^rd_cell);
  // a new error wins over a clear in the same cycle
  wire        next_par_err = rd_bad || (par_err_out && !par_err_clr_in);

  reg  [14:0] next_pc;
  reg  [4:0]  next_state;

  always @*
  begin
    next_pc    = pc_out;
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (start_in)
        begin
          next_pc    = start_addr_in - 15'h0001;
          next_state = ST_ADV;
        end
      end
      ST_ADV:
      begin
        next_pc    = pc_out + 15'h0001;
        next_state = ST_FETCH;
      end
      ST_FETCH:
      begin
        if (fetch_go)
          next_state = ST_FWAIT;
      end
      ST_FWAIT:
      begin
        if (rd_done)
          next_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (exec_done_in)
        begin
          case (exec_kind_in)
            `CMFS_EX_HALT:
              next_state = ST_IDLE;
            `CMFS_EX_BRANCH:
            begin
              next_pc    = exec_target_in;
              next_state = ST_FETCH;
            end
            `CMFS_EX_SKIP:
            begin
              next_pc    = skip_cond_in ? pc_out + 15'h0002 : pc_out + 15'h0001;
              next_state = ST_FETCH;
            end
            default:
              next_state = ST_ADV;
          endcase
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  reg  [14:0] host_addr;
  wire        host_end  = req_busy_out && rd_done;
  wire        host_ctl  = host_end && !host_wr && (host_dest == `CMFS_DEST_CTL);
  wire        halt_take = (state == ST_EXEC) && exec_done_in &&
                          (exec_kind_in == `CMFS_EX_HALT);

  // sequencer state and program counter
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state  <= ST_IDLE;
      pc_out <= 15'h0000;
    end
    else
    begin
      state  <= next_state;
      pc_out <= next_pc;
    end
  end

  // run flag follows the sequencer; halt pulse marks the stopping edge
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      running_out <= 1'b0;
      halted_out  <= 1'b0;
    end
    else
    begin
      running_out <= (next_state != ST_IDLE);
      halted_out  <= halt_take;
    end
  end

  // host request kept here so the requester may drop its address after accept
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      cur_mod      <= 2'h0;
      host_wr      <= 1'b0;
      host_dest    <= `CMFS_DEST_CTL;
      host_addr    <= 15'h0000;
      req_busy_out <= 1'b0;
    end
    else
    begin
      if (host_acc)
      begin
        req_busy_out <= 1'b1;
        host_wr      <= req_write_in;
        host_dest    <= req_dest_in;
        host_addr    <= req_addr_in;
        cur_mod      <= host_mod;
      end
      else
      begin
        if (fetch_go)
          cur_mod <= fetch_mod;
        if (host_end)
          req_busy_out <= 1'b0;
      end
    end
  end

  always @(posedge core_clk_in)
  begin
    if (srst_in)
      wr_done_out <= 1'b0;
    else
      wr_done_out <= host_end && host_wr;
  end

  // operand path to arithmetic
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      oper_valid_out <= 1'b0;
      oper_word_out  <= 16'h0000;
    end
    else
    begin
      oper_valid_out <= 1'b0;
      if (host_end && !host_wr && (host_dest == `CMFS_DEST_ARITH))
      begin
        oper_valid_out <= 1'b1;
        oper_word_out  <= rd_cell[15:0];
      end
    end
  end

  // word path to control: a fetch or a host read aimed at control
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      instr_valid_out <= 1'b0;
      instr_word_out  <= 16'h0000;
      instr_addr_out  <= 15'h0000;
    end
    else
    begin
      instr_valid_out <= 1'b0;
      if (host_ctl)
      begin
        instr_valid_out <= 1'b1;
        instr_word_out  <= rd_cell[15:0];
        instr_addr_out  <= host_addr;
      end
      else if (fetch_rd)
      begin
        instr_valid_out <= 1'b1;
        instr_word_out  <= rd_cell[15:0];
        instr_addr_out  <= pc_out;
      end
    end
  end

  always @(posedge core_clk_in)
  begin
    if (srst_in)
      par_err_out <= 1'b0;
    else
      par_err_out <= next_par_err;
  end
endmodule
`default_nettype wire

/* testbench/cmfs_core_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cmfs_consts.vh"
module cmfs_core_checker (
  input wire logic        core_clk_in,     // clock
  input wire logic        srst_in,         // reset
  input wire logic        start_in,        // start pulse
  input wire logic [14:0] start_addr_in,   // first address
  input wire logic        req_busy_out,    // request in flight
  input wire logic        wr_done_out,     // write done
  input wire logic        instr_valid_out, // word to control
  input wire logic [14:0] instr_addr_out,  // its address
  input wire logic        oper_valid_out,  // word to arithmetic
  input wire logic        par_err_out,     // parity flag
  input wire logic        par_err_clr_in,  // parity clear
  input wire logic [14:0] pc_out,          // program counter
  input wire logic        running_out,     // executing
  input wire logic        halted_out       // halt pulse
);
  localparam int CYC = `CMFS_CYCLE_CLKS;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_go; start_in && !running_out; endsequence
  sequence s_load;
    ##1 running_out && pc_out == $past(start_addr_in) - 15'h1 ##1 pc_out == $past(start_addr_in, 2);
  endsequence
  property p_cycle; $rose(req_busy_out) |-> ##CYC req_busy_out ##1 !req_busy_out; endproperty
  a_cycle: assert property (p_cycle) else $error("memory cycle length");
  property p_ans; $fell(req_busy_out) |-> wr_done_out || instr_valid_out || oper_valid_out; endproperty
  a_ans: assert property (p_ans) else $error("no answer at cycle end");
  property p_wr; wr_done_out |-> $fell(req_busy_out); endproperty
  a_wr: assert property (p_wr) else $error("stray write done");
  property p_oper; oper_valid_out |-> $fell(req_busy_out); endproperty
  a_oper: assert property (p_oper) else $error("stray operand");
  property p_halt; halted_out |-> !running_out && $past(running_out); endproperty
  a_halt: assert property (p_halt) else $error("halt without stop");
  property p_start; s_go |-> s_load; endproperty
  a_start: assert property (p_start) else $error("bad start load");
  property p_hold; !running_out && !start_in |=> $stable(pc_out); endproperty
  a_hold: assert property (p_hold) else $error("counter moved while stopped");
  property p_fetch; instr_valid_out && running_out && !$past(req_busy_out) |-> instr_addr_out == pc_out; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not at counter");
  property p_par; $past(par_err_out) && !$past(par_err_clr_in) |-> par_err_out; endproperty
  a_par: assert property (p_par) else $error("parity flag dropped");
endmodule
`default_nettype wire

/* testbench/cmfs_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cmfs_ctl_model (
  input  wire logic        core_clk_in,    // clock
  input  wire logic        instr_valid_in, // fetched word
  input  wire logic        running_in,     // executing
  output logic             exec_done_out,  // instruction finished
  output logic [1:0]       exec_kind_out,  // its kind
  output logic [14:0]      target_out,     // branch target
  output logic             cond_out        // skip condition
);
  // program: next, skip taken, skip not taken, branch, next, halt
  localparam logic [11:0] KINDS = {2'h1, 2'h0, 2'h2, 2'h3, 2'h3, 2'h0};
  logic [2:0] step;
  initial
  begin
    {exec_done_out, exec_kind_out, cond_out, step} = '0;
    target_out = 15'h0040;
  end
  always @(negedge core_clk_in)
  begin
    exec_done_out <= 1'b0;
    if (instr_valid_in && running_in && step < 3'h6)
    begin
      exec_done_out <= 1'b1;
      exec_kind_out <= KINDS[step*2 +: 2];
      cond_out      <= (step == 3'h1);
      step          <= step + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* testbench/cmfs_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cmfs_core_tb;
  logic        core_clk_in = 1'b0, srst_in = 1'b1, start_in = 1'b0, par_err_clr_in = 1'b0;
  logic        req_valid_in = 1'b0, req_write_in = 1'b0, req_dest_in = 1'b0;
  logic [14:0] start_addr_in = 15'h0, req_addr_in = 15'h0;
  logic [15:0] req_wdata_in = 16'h0;
  wire         exec_done_in, skip_cond_in, req_busy_out, wr_done_out, instr_valid_out;
  wire         oper_valid_out, par_err_out, running_out, halted_out;
  wire [1:0]   exec_kind_in;
  wire [14:0]  exec_target_in, instr_addr_out, pc_out;
  wire [15:0]  instr_word_out, oper_word_out;
  int          n_errors = 0, num_checks = 0;
  cmfs_core cmfs_core_inst (.core_clk_in, .srst_in, .start_in, .start_addr_in, .req_valid_in,
    .req_write_in, .req_dest_in, .req_addr_in, .req_wdata_in, .exec_done_in, .exec_kind_in,
    .exec_target_in, .skip_cond_in, .par_err_clr_in, .req_busy_out, .wr_done_out,
    .instr_valid_out, .instr_word_out, .instr_addr_out, .oper_valid_out, .oper_word_out,
    .par_err_out, .pc_out, .running_out, .halted_out);
  cmfs_ctl_model cmfs_ctl_model_inst (.core_clk_in, .instr_valid_in(instr_valid_out),
    .running_in(running_out), .exec_done_out(exec_done_in), .exec_kind_out(exec_kind_in),
    .target_out(exec_target_in), .cond_out(skip_cond_in));
  always #4 core_clk_in = ~core_clk_in;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task automatic close_out;
  begin
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // request held until busy rises, address held until the answer
  task automatic mem_op(input logic wr, dst, input logic [14:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
  begin
    n = 0;
    @(negedge core_clk_in);
    {req_valid_in, req_write_in, req_dest_in, req_addr_in, req_wdata_in} = {1'b1, wr, dst, a, d};
    while (req_busy_out !== 1'b1 && n < 400)
    begin
      @(negedge core_clk_in);
      n++;
    end
    req_valid_in = 1'b0;
    while ((wr_done_out | instr_valid_out | oper_valid_out) !== 1'b1 && n < 400)
    begin
      @(negedge core_clk_in);
      n++;
    end
    q = dst ? oper_word_out : instr_word_out;
    check("answer pulse", {15'h0, wr ? wr_done_out : dst ? oper_valid_out : instr_valid_out}, 16'h1);
  end
  endtask
  task automatic t_mem;
    logic [14:0] a;
    logic [15:0] q;
    int j;
  begin
    for (int i = 0; i < 15; i++)
    begin
      j = i % 5;
      a = (j < 4) ? {j[1:0], 13'h0123} : 15'h7fff;
      mem_op(i < 5, i < 10, a, 16'(16'h1111 * (j + 1)), q);
      if (i >= 5)
        check("read word", q, 16'(16'h1111 * (j + 1)));
    end
    @(negedge core_clk_in);
    par_err_clr_in = 1'b1;
    @(negedge core_clk_in);
    par_err_clr_in = 1'b0;
    check("parity flag", {15'h0, par_err_out}, 16'h0);
  end
  endtask
  task automatic t_prog;
    logic [14:0] exp [0:5] = '{15'h10, 15'h11, 15'h13, 15'h14, 15'h40, 15'h41};
    logic [15:0] q;
    int n;
  begin
    foreach (exp[k])
      mem_op(1'b1, 1'b0, exp[k], {1'b0, exp[k]} ^ 16'h5a5a, q);
    @(negedge core_clk_in);
    start_in = 1'b1;
    start_addr_in = 15'h0010;
    @(negedge core_clk_in);
    start_in = 1'b0;
    start_addr_in = 15'h0300;
    check("first counter", {1'b0, pc_out}, 16'h000f);
    @(negedge core_clk_in);
    check("counter advanced", {1'b0, pc_out}, 16'h0010);
    for (int k = 0; k < 6; k++)
    begin
      n = 0;
      while (instr_valid_out !== 1'b1 && n < 400)
      begin
        @(negedge core_clk_in);
        n++;
        start_in = (k == 2 && n == 5); // a start while running is ignored
      end
      check("fetch address", {1'b0, instr_addr_out}, {1'b0, exp[k]});
      check("fetch word", instr_word_out, {1'b0, exp[k]} ^ 16'h5a5a);
      @(negedge core_clk_in);
    end
    check("halt pulse", {15'h0, halted_out}, 16'h1);
    n = 0;
    while (running_out !== 1'b0 && n < 10)
    begin
      @(negedge core_clk_in);
      n++;
    end
    check("stopped", {15'h0, running_out}, 16'h0);
    check("halt counter", {1'b0, pc_out}, 16'h0041);
  end
  endtask
  initial
  begin
    #80000;
    n_errors++;
    close_out;
  end
  initial
  begin
    repeat (16) @(negedge core_clk_in);
    srst_in = 1'b0;
    t_mem;
    t_prog;
    close_out;
  end
endmodule
bind cmfs_core cmfs_core_checker cmfs_core_checker_inst (.core_clk_in, .srst_in, .start_in,
  .start_addr_in, .req_busy_out, .wr_done_out, .instr_valid_out, .instr_addr_out,
  .oper_valid_out, .par_err_out, .par_err_clr_in, .pc_out, .running_out, .halted_out);
`default_nettype wire
